// file: hdl/tdcs_cfg.svh
/*
  Constants of the trellis decoder configuration and status block.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef TDCS_CFG_SVH
`define TDCS_CFG_SVH
`define TDCS_STATE_W       6
`define TDCS_SOFT_W        3
`define TDCS_LANES         2
`define TDCS_METRIC_W      16
`define TDCS_CODE_W        2
`define TDCS_ROT_W         1
`define TDCS_DEPTH_W       8
`define TDCS_NORM_W        8
`define TDCS_ERR_W         16
`define TDCS_PACE_W        2
`define TDCS_PACE_LAST     2'h3
`define TDCS_NORM_LIMIT    16'h8000
`define TDCS_ERR_DELAY_W   2
`define TDCS_ERR_DELAY     2'h2
`define TDCS_ITEM_W        4
`define TDCS_ITEM_BIT      0
`define TDCS_ITEM_LAST     1
`define TDCS_ITEM_FIRST    2
`define TDCS_ITEM_ERR      3
`define TDCS_FIFO_DEPTH    2
`define TDCS_FIFO_PTR_W    1
`define TDCS_FIFO_CNT_W    2
`define TDCS_FIFO_FULL     2'h2
`define TDCS_FIFO_EMPTY    2'h0
`define TDCS_ORIGIN_ZERO   6'h00
`endif

// file: hdl/tdcs_error_counter.sv
/*
  Per-block error counter with clear and delayed validity flag.
  Assumes strobes come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "tdcs_cfg.svh"
module tdcs_error_counter
  import tdcs_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   clear,
  input  wire logic                   blockStart,
  input  wire logic                   errorSeen,
  output logic [`TDCS_ERR_W-1:0]      count,
  output logic                        countValid
);
  logic [`TDCS_ERR_DELAY_W-1:0] delay;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (blockStart) begin
      count <= {{(`TDCS_ERR_W-1){1'b0}}, errorSeen};
    end else if (errorSeen) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      delay      <= '0;
      countValid <= 1'b0;
    end else if (blockStart) begin
      delay      <= `TDCS_ERR_DELAY - 1'b1;
      countValid <= 1'b0;
    end else if (delay != '0) begin
      delay      <= delay - 1'b1;
    end else begin
      countValid <= 1'b1;
    end
  end

  error_valid_delay_a: assert property (@(posedge clk) disable iff (reset)
    blockStart ##1 !blockStart [*2] |-> !$past(countValid) && !countValid ##1 countValid)
    else $error("error count not valid two cycles after block start");
endmodule : tdcs_error_counter

// file: hdl/tdcs_pkg.sv
/*
  Types shared by the trellis decoder configuration and status modules.
  Assumes tdcs_cfg.svh is on the include path.
*/
`include "tdcs_cfg.svh"
package tdcs_pkg;
  typedef logic [`TDCS_STATE_W-1:0]  tdcs_state_t;
  typedef logic [`TDCS_METRIC_W-1:0] tdcs_metric_t;
  typedef logic [`TDCS_SOFT_W-1:0]   tdcs_soft_t;
  typedef logic [`TDCS_ITEM_W-1:0]   tdcs_item_t;
  typedef enum logic [1:0] {
    TDCS_IDLE     = 2'b00,
    TDCS_IN_BLOCK = 2'b01
  } tdcs_phase_t;
endpackage : tdcs_pkg

// file: hdl/tdcs_skid_buffer.sv
/*
  Two-entry buffer in the decoded-bit path; a stalled reader loses no word.
  Assumes clk and an active-high asynchronous reset.
*/
`timescale 1ns/100ps
`include "tdcs_cfg.svh"
module tdcs_skid_buffer
  import tdcs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset,
  tdcs_stream_if.sink   upstream,
  tdcs_stream_if.source downstream
);
  tdcs_item_t                    mem [`TDCS_FIFO_DEPTH];
  logic [`TDCS_FIFO_PTR_W-1:0]   wrPtr;
  logic [`TDCS_FIFO_PTR_W-1:0]   rdPtr;
  logic [`TDCS_FIFO_CNT_W-1:0]   fill;
  logic                          push;
  logic                          pop;

  assign upstream.ready   = (fill != `TDCS_FIFO_FULL);
  assign downstream.valid = (fill != `TDCS_FIFO_EMPTY);
  assign downstream.data  = mem[rdPtr];
  assign push             = upstream.valid && upstream.ready;
  assign pop              = downstream.valid && downstream.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= upstream.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  buffer_no_overflow_a: assert property (@(posedge clk) disable iff (reset)
    (fill == `TDCS_FIFO_FULL) |-> !push)
    else $error("buffer written while full");
endmodule : tdcs_skid_buffer

// file: hdl/tdcs_stream_if.sv
/*
  Valid/ready word stream between the decoder core and its output buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface tdcs_stream_if;
  import tdcs_pkg::*;
  logic       valid;
  logic       ready;
  tdcs_item_t data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : tdcs_stream_if

// file: hdl/trellis_decoder_config_status.sv
/*
  Configuration latching, status reporting and stream handshakes of a
  trellis decoder; the decoding datapath is a compact stand-in.
  Assumes user logic on clk drives both stream sides.
*/
`timescale 1ns/100ps
`include "tdcs_cfg.svh"
module trellis_decoder_config_status
  import tdcs_pkg::*;
#(
  parameter bit CONTINUOUS_OPT = 1'b0
)
(
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic                                 input_valid,
  output logic                                      input_accept_ready,
  input  wire logic                                 input_block_first,
  input  wire logic                                 input_block_last,
  input  wire logic [`TDCS_LANES*`TDCS_SOFT_W-1:0]  soft_symbols,
  input  wire logic [`TDCS_LANES-1:0]               erasure_marks,
  input  wire logic [`TDCS_STATE_W-1:0]             preload_state_select,
  input  wire logic [`TDCS_METRIC_W-1:0]            preload_metric_value,
  input  wire logic [`TDCS_CODE_W-1:0]              code_select,
  input  wire logic [`TDCS_ROT_W-1:0]               node_sync_rotation,
  input  wire logic [`TDCS_DEPTH_W-1:0]             traceback_depth,
  input  wire logic                                 traceback_start_mode,
  input  wire logic [`TDCS_STATE_W-1:0]             traceback_start_state,
  input  wire logic                                 error_rate_counter_clear,
  output logic                                      decoded_bit,
  output logic                                      output_valid,
  output logic                                      output_block_first,
  output logic                                      output_block_last,
  input  wire logic                                 output_accept_ready,
  output logic [`TDCS_METRIC_W-1:0]                 leading_path_metric,
  output logic [`TDCS_STATE_W-1:0]                  leading_state_index,
  output logic [`TDCS_NORM_W-1:0]                   normalization_count,
  output logic [`TDCS_ERR_W-1:0]                    block_error_count,
  output logic                                      error_count_valid,
  output logic [`TDCS_CODE_W-1:0]                   active_code,
  output logic [`TDCS_DEPTH_W-1:0]                  active_traceback_depth,
  output logic [`TDCS_STATE_W-1:0]                  traceback_origin
);

  // soft value: MSB is the hard decision, remaining bits the confidence
  function automatic tdcs_soft_t laneOf(input logic [`TDCS_LANES*`TDCS_SOFT_W-1:0] bus,
                                        input int unsigned idx);
    laneOf = bus[idx*`TDCS_SOFT_W +: `TDCS_SOFT_W];
  endfunction : laneOf

  function automatic tdcs_metric_t confidence(input tdcs_soft_t s, input logic erased);
    tdcs_metric_t c;
    c = '0;
    if (!erased) begin
      c = tdcs_metric_t'(s[`TDCS_SOFT_W-2:0]);
    end
    confidence = c;
  endfunction : confidence

  tdcs_stream_if pushIf ();
  tdcs_stream_if popIf ();

  tdcs_phase_t                         phase;
  tdcs_phase_t                         next_phase;
  logic [`TDCS_PACE_W-1:0]             paceCount;
  logic                                accept;
  logic                                firstTaken;
  logic                                lastTaken;
  logic [`TDCS_ROT_W-1:0]              rotation;
  logic                                blockMode;
  tdcs_state_t                         blockStartState;
  tdcs_soft_t                          lane0;
  tdcs_soft_t                          lane1;
  logic                                erase0;
  logic                                erase1;
  tdcs_metric_t                        branchMetric;
  tdcs_metric_t                        next_metric;
  logic                                needNorm;
  logic                                stepBit;
  logic                                stepErr;
  logic                                pendingValid;
  tdcs_item_t                          pendingItem;
  logic                                readySampled;
  logic                                popTaken;

  assign accept     = input_valid && input_accept_ready;
  assign firstTaken = accept && input_block_first;
  assign lastTaken  = accept && input_block_last;

  // lane swap for node synchronisation, applied with the rotation of the block
  always_comb begin
    lane0  = laneOf(soft_symbols, 0);
    lane1  = laneOf(soft_symbols, 1);
    erase0 = erasure_marks[0];
    erase1 = erasure_marks[1];
    if (firstTaken ? node_sync_rotation[0] : rotation[0]) begin
      lane0  = laneOf(soft_symbols, 1);
      lane1  = laneOf(soft_symbols, 0);
      erase0 = erasure_marks[1];
      erase1 = erasure_marks[0];
    end
  end

  always_comb begin
    branchMetric = confidence(lane0, erase0) + confidence(lane1, erase1);
    stepBit      = erase0 ? lane1[`TDCS_SOFT_W-1] : lane0[`TDCS_SOFT_W-1];
    stepErr      = !erase0 && !erase1 &&
                   (lane0[`TDCS_SOFT_W-1] != lane1[`TDCS_SOFT_W-1]);
    next_metric  = (firstTaken ? preload_metric_value : leading_path_metric) + branchMetric;
    needNorm     = next_metric >= `TDCS_NORM_LIMIT;
  end

  // block framing: a block opens on an accepted first and closes on an accepted last
  always_comb begin
    next_phase = phase;
    case (phase)
      TDCS_IDLE:     if (firstTaken && !lastTaken) next_phase = TDCS_IN_BLOCK;
      TDCS_IN_BLOCK: if (lastTaken && !firstTaken) next_phase = TDCS_IDLE;
      default:       next_phase = TDCS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= TDCS_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // input pacing: one ready cycle per Z, withheld while the path cannot take a word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      paceCount          <= '0;
      input_accept_ready <= 1'b0;
    end else begin
      paceCount          <= (paceCount == `TDCS_PACE_LAST) ? '0 : paceCount + 1'b1;
      input_accept_ready <= (paceCount == `TDCS_PACE_LAST) &&
                            pushIf.ready && !pendingValid;
    end
  end

  // configuration held for the whole block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_code            <= '0;
      rotation               <= '0;
      active_traceback_depth <= '0;
      blockStartState        <= '0;
    end else if (firstTaken) begin
      active_code            <= code_select;
      rotation               <= node_sync_rotation;
      active_traceback_depth <= CONTINUOUS_OPT ? '0 : traceback_depth;
      blockStartState        <= preload_state_select;
    end
  end

  // traceback origin taken at the block end marker
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blockMode        <= 1'b0;
      traceback_origin <= `TDCS_ORIGIN_ZERO;
    end else if (lastTaken) begin
      blockMode <= CONTINUOUS_OPT ? 1'b0 : traceback_start_mode;
      if (CONTINUOUS_OPT || !traceback_start_mode) begin
        traceback_origin <= `TDCS_ORIGIN_ZERO;
      end else begin
        traceback_origin <= traceback_start_state;
      end
    end
  end

  // best-state tracking per trellis step, with metric normalisation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      leading_path_metric <= '0;
      leading_state_index <= '0;
    end else if (accept) begin
      leading_path_metric <= needNorm ? next_metric - `TDCS_NORM_LIMIT : next_metric;
      leading_state_index <= firstTaken ?
        {preload_state_select[`TDCS_STATE_W-2:0], stepBit} :
        {leading_state_index[`TDCS_STATE_W-2:0], stepBit};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      normalization_count <= '0;
    end else if (firstTaken) begin
      normalization_count <= {{(`TDCS_NORM_W-1){1'b0}}, needNorm};
    end else if (accept && needNorm) begin
      normalization_count <= normalization_count + 1'b1;
    end
  end

  // decoded word waits here until the buffer takes it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pendingValid <= 1'b0;
      pendingItem  <= '0;
    end else if (accept) begin
      pendingValid                 <= 1'b1;
      pendingItem[`TDCS_ITEM_BIT]  <= stepBit;
      pendingItem[`TDCS_ITEM_LAST] <= input_block_last;
      pendingItem[`TDCS_ITEM_FIRST]<= input_block_first;
      pendingItem[`TDCS_ITEM_ERR]  <= stepErr;
    end else if (pushIf.ready) begin
      pendingValid <= 1'b0;
    end
  end

  assign pushIf.valid = pendingValid;
  assign pushIf.data  = pendingItem;

  tdcs_skid_buffer u_buffer (
    .clk        (clk),
    .reset      (reset),
    .upstream   (pushIf.sink),
    .downstream (popIf.source)
  );

  // ready is sampled at one edge, the bit goes out at the next
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readySampled <= 1'b0;
    end else begin
      readySampled <= output_accept_ready;
    end
  end

  assign popIf.ready = readySampled;
  assign popTaken    = popIf.valid && readySampled;

  // output stays valid on every cycle while data remains and ready holds
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      output_valid       <= 1'b0;
      decoded_bit        <= 1'b0;
      output_block_first <= 1'b0;
      output_block_last  <= 1'b0;
    end else begin
      output_valid       <= popTaken;
      output_block_first <= popTaken && popIf.data[`TDCS_ITEM_FIRST];
      output_block_last  <= popTaken && popIf.data[`TDCS_ITEM_LAST];
      if (popTaken) begin
        decoded_bit <= popIf.data[`TDCS_ITEM_BIT];
      end
    end
  end

  tdcs_error_counter u_errors (
    .clk        (clk),
    .reset      (reset),
    .clear      (error_rate_counter_clear),
    .blockStart (popTaken && popIf.data[`TDCS_ITEM_FIRST]),
    .errorSeen  (popTaken && popIf.data[`TDCS_ITEM_ERR]),
    .count      (block_error_count),
    .countValid (error_count_valid)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence readySeen_s;
    output_accept_ready;
  endsequence

  sequence wordPending_s;
    popIf.valid;
  endsequence

  output_after_ready_a: assert property (
    output_valid |-> $past(output_accept_ready, 2))
    else $error("output valid without ready sampled two edges before");

  output_follows_ready_a: assert property (
    readySeen_s ##1 (wordPending_s and readySampled) |=> output_valid)
    else $error("sampled ready and pending word gave no output");

  input_pacing_a: assert property (
    input_accept_ready |=> !input_accept_ready [*3])
    else $error("input ready asserted more than once per period");

  input_backpressure_a: assert property (
    (pendingValid && !pushIf.ready) |=> !input_accept_ready)
    else $error("input ready while decoded word stalled");

  code_latch_a: assert property (
    firstTaken |=> active_code == $past(code_select))
    else $error("code select not latched at block first");

  config_hold_a: assert property (
    !firstTaken |=> $stable(active_traceback_depth) && $stable(active_code))
    else $error("block configuration changed inside a block");

  origin_select_a: assert property (
    (lastTaken && !traceback_start_mode) |=> traceback_origin == `TDCS_ORIGIN_ZERO)
    else $error("traceback origin not zero in low start mode");

  origin_state_a: assert property (
    (lastTaken && traceback_start_mode && !CONTINUOUS_OPT)
      |=> traceback_origin == $past(traceback_start_state) && blockMode)
    else $error("traceback origin not taken from start state");

  norm_restart_a: assert property (
    (firstTaken && !needNorm) |=> normalization_count == '0)
    else $error("normalization count not restarted at block first");

  norm_step_a: assert property (
    (accept && !firstTaken && needNorm)
      |=> normalization_count == $past(normalization_count) + 1'b1)
    else $error("normalization not counted");

  preload_state_a: assert property (
    firstTaken |=> leading_state_index[`TDCS_STATE_W-1:1] ==
                   $past(preload_state_select[`TDCS_STATE_W-2:0]))
    else $error("state not preloaded at block first");

  error_clear_a: assert property (
    error_rate_counter_clear |=> block_error_count == '0)
    else $error("error counter not cleared");

  one_pulse_per_bit_a: assert property (
    output_valid |-> $past(popTaken))
    else $error("output valid without a decoded bit");

endmodule : trellis_decoder_config_status

// file: tb/tb.sv
/*
  Self-checking bench of the trellis decoder configuration and status block.
  Assumes tdcs_cfg.svh on the include path and the sink model compiled first.
*/
`timescale 1ns/100ps
`include "tdcs_cfg.svh"
module tb;
  import tdcs_pkg::*;
  logic clk, reset, iv, first, last, mode, clr, stall, rot;
  logic [5:0] sym;
  logic [1:0] eras, code;
  logic [7:0] depth;
  tdcs_state_t sst;
  logic iRdy, oBit, oVal, oRdy, eVal, oFirst, oLast;
  logic [15:0] pmv, lpm;
  tdcs_state_t lsi;
  logic [1:0] fl[$];
  logic [15:0] eCnt;
  logic [7:0] nCnt, aDepth;
  logic [1:0] aCode;
  tdcs_state_t origin;
  logic exq[$];
  int num_errors, comparisons, gap, sp;
  trellis_decoder_config_status i_trellis_decoder_config_status (.clk(clk), .reset(reset),
    .input_valid(iv), .input_accept_ready(iRdy), .input_block_first(first),
    .input_block_last(last), .soft_symbols(sym), .erasure_marks(eras),
    .preload_state_select(sst), .preload_metric_value(pmv),
    .code_select(code), .node_sync_rotation(rot), .traceback_depth(depth),
    .traceback_start_mode(mode), .traceback_start_state(sst),
    .error_rate_counter_clear(clr), .decoded_bit(oBit), .output_valid(oVal),
    .output_block_first(oFirst), .output_block_last(oLast), .output_accept_ready(oRdy),
    .leading_path_metric(lpm), .leading_state_index(lsi), .normalization_count(nCnt),
    .block_error_count(eCnt), .error_count_valid(eVal), .active_code(aCode),
    .active_traceback_depth(aDepth), .traceback_origin(origin));
  tdcs_sink_model i_tdcs_sink_model (.clk(clk), .reset(reset), .outValid(oVal),
    .outBit(oBit), .stall(stall), .outReady(oRdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("compared %0d, wrong %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [1:0] exp_of(logic [5:0] s, logic [1:0] e, logic r);
    logic [5:0] t;
    logic [1:0] m;
    t = r ? {s[2:0], s[5:3]} : s;
    m = r ? {e[0], e[1]} : e;
    return {m == 2'h0 && t[5] != t[2], m[0] ? t[5] : t[2]};
  endfunction : exp_of
  // the bench itself watches the ready pulse spacing and the pulses taken in a stall
  always @(posedge clk) begin
    if (iRdy === 1'b1 && gap > 0) chk(gap >= 4, 1'b1);
    gap <= (iRdy === 1'b1) ? 1 : gap + 1;
    if (iRdy === 1'b1 && stall) sp <= sp + 1;
    if (oVal === 1'b1) fl.push_back({oFirst, oLast});
  end
  task automatic blk(int n, logic [1:0] c, logic r, logic m);
    logic [7:0] d;
    tdcs_state_t s;
    logic [5:0] y;
    logic [1:0] x, ex;
    int e, w, nc;
    logic [15:0] p, met;
    tdcs_state_t st;
    d = 8'($urandom);
    s = 6'($urandom);
    e = 0;
    nc = 0;
    p = 16'($urandom_range(32'h7FFF, 32'h7FD0));
    met = p;
    st = (n == 1) ? s : ~s;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      y = 6'($urandom);
      x = 2'($urandom_range(2));
      ex = exp_of(y, x, r);
      met = met + (x[0] ? 16'h0 : 16'(y[1:0])) + (x[1] ? 16'h0 : 16'(y[4:3]));
      if (met >= `TDCS_NORM_LIMIT) begin
        met = met - `TDCS_NORM_LIMIT;
        nc++;
      end
      st = {st[4:0], ex[0]};
      sym <= y;
      eras <= x;
      first <= (i == 0);
      last <= (i == n - 1);
      code <= (i == 0) ? c : ~c;
      depth <= (i == 0) ? d : ~d;
      rot <= (i == 0) ? r : ~r;
      mode <= (i == n - 1) ? m : ~m;
      sst <= (i == n - 1) ? s : ~s;
      pmv <= (i == 0) ? p : ~p;
      iv <= 1'b1;
      for (w = 0; w < 300; w++) begin
        @(posedge clk);
        if (iRdy === 1'b1) break;
      end
      if (w == 300) begin
        num_errors++;
        test_done;
      end
      @(posedge clk);
      exq.push_back(ex[0]);
      e += ex[1];
      if (i == 0) chk(aCode, c);
    end
    iv <= 1'b0;
    for (w = 0; w < 300 && i_tdcs_sink_model.got.size() < exq.size(); w++) @(posedge clk);
    if (w == 300) begin
      num_errors++;
      test_done;
    end
    repeat (4) @(posedge clk);
    chk(i_tdcs_sink_model.got.size(), exq.size());
    foreach (exq[i]) chk(i_tdcs_sink_model.got[i], exq[i]);
    chk(aCode, c);
    chk(aDepth, d);
    chk(origin, m ? s : 6'h00);
    chk(eCnt, e);
    chk(eVal, 1'b1);
    chk(nCnt, nc);
    chk(lpm, met);
    chk(lsi, st);
    chk(fl.size(), n);
    foreach (fl[i]) chk(fl[i], {i == 0, i == n - 1});
    exq.delete();
    fl.delete();
    i_tdcs_sink_model.got.delete();
    $display("block of %0d words done", n);
  endtask : blk
  initial begin
    {iv, first, last, mode, clr, stall, rot, sym, eras, code, depth, sst, pmv} = '0;
    gap = 0;
    sp = 0;
    reset = 1'b1;
    void'($urandom(32'hBA49));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({iRdy, oVal}, 2'h0);
    chk(eCnt, 16'h0);
    for (int k = 0; k < 4; k++)
      blk(k == 0 ? 1 : $urandom_range(6, 2), 2'(k), k[0], k != 1);
    stall <= 1'b1;
    fork
      blk(8, 2'h1, 1'b0, 1'b1);
      begin
        repeat (150) @(posedge clk);
        chk(sp <= 5, 1'b1);
        stall <= 1'b0;
      end
    join
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(eCnt, 16'h0);
    $display("clear test done");
    test_done;
  end
endmodule : tb

// file: tb/tdcs_sink_model.sv
/*
  User logic on the decoded-bit side: takes bits, stalls at random or on demand.
  Assumes clk and an active-high asynchronous reset shared with the decoder.
*/
`timescale 1ns/100ps
module tdcs_sink_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic outValid,
  input  wire logic outBit,
  input  wire logic stall,
  output logic      outReady
);
  logic got[$];
  always @(posedge clk or posedge reset) begin
    if (reset) outReady <= 1'b0;
    else outReady <= !stall && ($urandom_range(3) != 0);
  end
  always @(posedge clk) begin
    if (!reset && outValid === 1'b1) got.push_back(outBit);
  end
endmodule : tdcs_sink_model
